// ===== verilog/hspp_port.sv
/*
  Handshake parallel port: data, direction and control/status registers
  behind an APB slave, an input strobe with latch and flag, an output
  strobe pulse and the combined maskable interrupt request.
  Assumes the mode pins are static and on the clk domain; port lines,
  the input strobe and the external interrupt line are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module hspp_port #(
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output var  logic             pready,
  output var  logic [31:0]      prdata,
  output var  logic             pslverr,
  // Operating mode
  input  wire logic [2:0]       mode_sel,
  // Port lines
  input  wire logic [DW-1:0]    port_lines_in,
  output var  logic [DW-1:0]    port_lines_out,
  output var  logic [DW-1:0]    port_lines_oe_b,
  // Strobe input pin
  input  wire logic             strobe_in_pin_in,
  output var  logic             strobe_in_pin_out,
  output var  logic             strobe_in_pin_oe_b,
  // Strobe output pin
  output var  logic             strobe_out_pin,
  output var  logic             strobe_out_pin_oe_b,
  // Interrupts
  input  wire logic             maskable_irq_line_b,
  output var  logic             irq_b
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (DW < 1 || DW > 8) begin : g_bad_width
    $error("hspp_port: DW must be 1 to 8");
  end

  // ************************************************************
  // Declarations
  // ************************************************************
  hspp_pkg::hspp_state_e state_q;
  logic [DW-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
  logic          stb_s1_q, stb_s2_q, stb_s3_q, stb_lvl_q;
  logic          irq_s1_q, irq_s2_q, irq_s3_q, ext_irq_q;
  logic [DW-1:0] data_q, dir_q, in_data_q, stage_q;
  logic          latch_en_q, stb_wr_q, irq_en_q, flag_q;
  logic          latch_open_q, armed_q, wpp_q, wtgt_dir_q, os_pend_q;
  logic          single_chip_mode_flag;
  logic          sel_data, sel_dir, sel_csr, acc_ok;
  logic          done, done_rd_data, done_data, os_trig, stb_fall;
  logic          data_reg_commit, dir_reg_commit;
  logic          port_read_couple, periph_read_couple;
  logic [DW-1:0] data_eff, dir_eff, port_val;
  logic [7:0]    csr_val;
  logic [31:0]   rd_val;

  // ************************************************************
  // Mode and address decode
  // ************************************************************
  // Single-chip operation flag
  assign single_chip_mode_flag = (mode_sel == hspp_pkg::MODE_SC_A) ||
                                 (mode_sel == hspp_pkg::MODE_SC_B);

  // Register select from word index
  always_comb begin
    sel_data = 1'b0;
    sel_dir  = 1'b0;
    sel_csr  = 1'b0;
    if (paddr[7:hspp_pkg::ADDR_LSB] ==
        hspp_pkg::IDX_DATA[5:0]) begin
      sel_data = 1'b1;
    end else if (paddr[7:hspp_pkg::ADDR_LSB] ==
                 hspp_pkg::IDX_DIR[5:0]) begin
      sel_dir = 1'b1;
    end else if (paddr[7:hspp_pkg::ADDR_LSB] ==
                 hspp_pkg::IDX_CSR[5:0]) begin
      sel_csr = 1'b1;
    end
  end

  // mode gating: all three registers only in single-chip mode
  assign acc_ok = single_chip_mode_flag && (sel_data || sel_dir || sel_csr)
                  && (paddr[1:0] == 2'b00);

  // Completed transfers
  assign done         = (state_q == hspp_pkg::ST_ACC) && psel && penable;
  assign done_data    = done && acc_ok && sel_data;
  assign done_rd_data = done_data && !pwrite;

  // ************************************************************
  // APB slave handshake
  // ************************************************************
  // One wait-free access phase after every setup cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= hspp_pkg::ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      case (state_q)
        hspp_pkg::ST_IDLE: begin
          if (psel && !penable) begin
            state_q <= hspp_pkg::ST_ACC;
            pready  <= 1'b1;
            pslverr <= !acc_ok;
          end
        end
        hspp_pkg::ST_ACC: begin
          if (psel && penable) begin
            state_q <= hspp_pkg::ST_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
          end
        end
        default: begin
          state_q <= hspp_pkg::ST_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // three-stage capture of strobe, pins and external interrupt
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      stb_s1_q <= 1'b1;
      stb_s2_q <= 1'b1;
      stb_s3_q <= 1'b1;
      irq_s1_q <= 1'b1;
      irq_s2_q <= 1'b1;
      irq_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= port_lines_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      stb_s1_q <= strobe_in_pin_in;
      stb_s2_q <= stb_s1_q;
      stb_s3_q <= stb_s2_q;
      irq_s1_q <= maskable_irq_line_b;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
    end
  end

  // Filtered levels: a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_lvl_q <= '0;
      stb_lvl_q <= 1'b1;
      ext_irq_q <= 1'b0;
    end else begin
      for (int i = 0; i < DW; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_lvl_q[i] <= pin_s3_q[i];
        end
      end
      if (stb_s2_q == stb_s3_q) begin
        stb_lvl_q <= stb_s3_q;
      end
      if (irq_s2_q == irq_s3_q) begin
        ext_irq_q <= !irq_s3_q;
      end
    end
  end

  // falling edge seen on the filtered strobe, single-chip only
  assign stb_fall = single_chip_mode_flag && stb_lvl_q &&
                    !stb_s2_q && !stb_s3_q;

  // ************************************************************
  // Control/status register
  // ************************************************************
  // three writable bits, cleared by reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_en_q <= hspp_pkg::RST_LATCH_EN;
      stb_wr_q   <= hspp_pkg::RST_STB_WR;
      irq_en_q   <= hspp_pkg::RST_IRQ_EN;
    end else if (done && pwrite && acc_ok && sel_csr && pstrb[0]) begin
      latch_en_q <= pwdata[hspp_pkg::CSR_LATCH_EN];
      stb_wr_q   <= pwdata[hspp_pkg::CSR_STB_WR];
      irq_en_q   <= pwdata[hspp_pkg::CSR_IRQ_EN];
    end
  end

  // arm the clear on a CSR read that returned the flag set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
    end else if (done && !pwrite && acc_ok && sel_csr) begin
      armed_q <= prdata[hspp_pkg::CSR_FLAG];
    end else if (done_data) begin
      armed_q <= 1'b0;
    end
  end

  // strobe fall sets the flag; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= hspp_pkg::RST_FLAG;
    end else if (stb_fall) begin
      flag_q <= 1'b1;
    end else if (armed_q && done_data) begin
      flag_q <= 1'b0;
    end
  end

  // ************************************************************
  // Write path: phase pulse then commit
  // ************************************************************
  // write phase pulse holds the staged value one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wpp_q      <= 1'b0;
      wtgt_dir_q <= 1'b0;
      stage_q    <= '0;
    end else begin
      wpp_q <= done && pwrite && acc_ok && (sel_data || sel_dir) && pstrb[0];
      if (done && pwrite) begin
        wtgt_dir_q <= sel_dir;
        stage_q    <= pwdata[DW-1:0];
      end
    end
  end

  assign data_reg_commit = wpp_q && !wtgt_dir_q;
  assign dir_reg_commit  = wpp_q && wtgt_dir_q;

  // commit into the selected register; reset makes lines inputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= hspp_pkg::RST_DATA[DW-1:0];
      dir_q  <= hspp_pkg::RST_DIR[DW-1:0];
    end else begin
      if (data_reg_commit) begin
        data_q <= stage_q;
      end
      if (dir_reg_commit) begin
        dir_q <= stage_q;
      end
    end
  end

  // ************************************************************
  // Input latch
  // ************************************************************
  // close on strobe fall, reopen after a data read or while the latch is disabled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_open_q <= hspp_pkg::RST_LATCH_OP;
    end else if (!latch_en_q) begin
      latch_open_q <= 1'b1;
    end else if (stb_fall && latch_open_q) begin
      latch_open_q <= 1'b0;
    end else if (done_rd_data) begin
      latch_open_q <= 1'b1;
    end
  end

  // transparent while open, captures pin levels when closing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_data_q <= '0;
    end else if (latch_open_q) begin
      in_data_q <= pin_lvl_q;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Values just committed are visible to a read that follows at once
  assign data_eff = data_reg_commit ? stage_q : data_q;
  assign dir_eff  = dir_reg_commit  ? stage_q : dir_q;

  // per line: driven level for outputs, input register for inputs
  for (genvar g = 0; g < DW; g++) begin : g_rd_bit
    assign port_val[g] = dir_eff[g] ? data_eff[g] : in_data_q[g];
  end

  // unused CSR bits read as zero
  always_comb begin
    csr_val                         = 8'h00;
    csr_val[hspp_pkg::CSR_LATCH_EN] = latch_en_q;
    csr_val[hspp_pkg::CSR_STB_WR]   = stb_wr_q;
    csr_val[hspp_pkg::CSR_IRQ_EN]   = irq_en_q;
    csr_val[hspp_pkg::CSR_FLAG]     = flag_q;
  end

  // data read couples the port value, other reads the register bus
  assign port_read_couple   = sel_data && !pwrite;
  assign periph_read_couple = !sel_data && !pwrite;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (acc_ok && port_read_couple) begin
      rd_val[DW-1:0] = port_val;
    end else if (acc_ok && periph_read_couple && sel_dir) begin
      rd_val[DW-1:0] = dir_eff;
    end else if (acc_ok && periph_read_couple && sel_csr) begin
      rd_val[7:0] = csr_val;
    end
  end

  // Read data taken in the setup cycle, held through the access phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (state_q == hspp_pkg::ST_IDLE && psel && !penable) begin
      prdata <= rd_val;
    end
  end

  // ************************************************************
  // Output strobe
  // ************************************************************
  // trigger follows the select bit
  assign os_trig = done_data && (pwrite == stb_wr_q);

  // one-cycle low pulse after the edge following the access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      os_pend_q <= 1'b0;
    end else begin
      os_pend_q <= os_trig;
    end
  end

  // ************************************************************
  // Pin drivers and interrupt
  // ************************************************************
  // strobe pins and port line drivers by mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_in_pin_out   <= 1'b1;
      strobe_in_pin_oe_b  <= 1'b1;
      strobe_out_pin      <= 1'b1;
      strobe_out_pin_oe_b <= 1'b0;
      port_lines_out      <= '0;
      port_lines_oe_b     <= '1;
    end else begin
      strobe_in_pin_out   <= 1'b1;
      strobe_in_pin_oe_b  <= single_chip_mode_flag;
      strobe_out_pin      <= !(single_chip_mode_flag && os_pend_q);
      strobe_out_pin_oe_b <= 1'b0;
      port_lines_out      <= data_q;
      port_lines_oe_b     <= single_chip_mode_flag ? ~dir_q : '1;
    end
  end

  // strobe request ORed with the external line
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_b <= 1'b1;
    end else begin
      irq_b <= !((flag_q && irq_en_q && single_chip_mode_flag) || ext_irq_q);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_flag_on_fall: assert property (stb_fall |=> flag_q)
    else $error("flag not set by strobe fall");
  a_flag_clear_seq: assert property (armed_q && done_data && !stb_fall
    |=> !flag_q ##1 (!flag_q || $past(stb_fall)))
    else $error("flag not cleared by read sequence");
  a_flag_keeps: assert property (flag_q && !(armed_q && done_data)
    |=> flag_q)
    else $error("flag cleared without sequence");
  a_irq_strobe: assert property (flag_q && irq_en_q && single_chip_mode_flag
    |=> !irq_b)
    else $error("strobe interrupt missing");
  a_irq_ext_or: assert property ($rose(ext_irq_q) |-> ##1 !irq_b)
    else $error("external interrupt not passed");
  a_irq_mode_gate: assert property (!single_chip_mode_flag && !ext_irq_q
    |=> irq_b)
    else $error("strobe interrupt outside single-chip");
  a_latch_closes: assert property (latch_en_q && latch_open_q && stb_fall
    |=> !latch_open_q ##1 $stable(in_data_q))
    else $error("latch did not close");
  a_latch_reopen: assert property (done_rd_data |=> latch_open_q)
    else $error("latch not reopened by read");
  a_latch_wr_keep: assert property (!latch_open_q && latch_en_q &&
    done_data && pwrite |=> !latch_open_q)
    else $error("write reopened the latch");
  a_os_pulse: assert property (os_trig && single_chip_mode_flag
    |-> ##1 strobe_out_pin ##1 !strobe_out_pin ##1 strobe_out_pin)
    else $error("output strobe pulse wrong");
  a_os_select: assert property (done_data && (pwrite != stb_wr_q)
    |-> ##2 strobe_out_pin)
    else $error("output strobe on wrong access");
  a_commit_data: assert property (data_reg_commit
    |=> !wpp_q ##1 port_lines_out == $past(stage_q, 2))
    else $error("data commit lost");
  a_mode_refuse: assert property (state_q == hspp_pkg::ST_ACC &&
    !single_chip_mode_flag |-> pslverr)
    else $error("access allowed outside single-chip");
  a_strobe_pin_dir: assert property (single_chip_mode_flag [*2]
    |-> strobe_in_pin_oe_b && !strobe_out_pin_oe_b)
    else $error("strobe pin direction wrong");

  c_flag_set:   cover property (stb_fall ##1 flag_q);
  c_clear_seq:  cover property (armed_q && done_data ##1 !flag_q);
  c_latch_use:  cover property (!latch_open_q ##[1:50] done_rd_data);
  c_os_pulse:   cover property (os_trig ##2 !strobe_out_pin);

endmodule : hspp_port
`default_nettype wire

// ===== verilog/hspp_pkg.sv
/*
  Constants for the handshake parallel port: register indices, CSR field
  positions, reset values, mode codes and bus slave states.
  Assumes a 32-bit APB bus in front; byte address is four times the index.
*/
`default_nettype none
package hspp_pkg;

  // ************************************************************
  // Register map (indices, byte address is index times four)
  // ************************************************************
  localparam logic [7:0] IDX_DIR  = 8'h04;     // Direction register
  localparam logic [7:0] IDX_DATA = 8'h06;     // Port data register
  localparam logic [7:0] IDX_CSR  = 8'h0F;     // Control/status register
  localparam int         ADDR_LSB = 2;         // Word aligned

  // ************************************************************
  // Control/status field positions
  // ************************************************************
  localparam int CSR_LATCH_EN = 3;
  localparam int CSR_STB_WR   = 4;
  localparam int CSR_IRQ_EN   = 6;
  localparam int CSR_FLAG     = 7;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic       RST_LATCH_EN = 1'b0;
  localparam logic       RST_STB_WR   = 1'b0;
  localparam logic       RST_IRQ_EN   = 1'b0;
  localparam logic       RST_FLAG     = 1'b0;
  localparam logic       RST_LATCH_OP = 1'b1;  // Latch starts transparent
  localparam logic [7:0] RST_DIR      = 8'h00; // All lines inputs
  localparam logic [7:0] RST_DATA     = 8'h00;

  // ************************************************************
  // Operating modes that count as single-chip operation
  // ************************************************************
  localparam logic [2:0] MODE_SC_A = 3'h4;
  localparam logic [2:0] MODE_SC_B = 3'h7;

  // ************************************************************
  // Bus slave states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC  = 2'b10
  } hspp_state_e;

endpackage : hspp_pkg
`default_nettype wire

// ===== tb/hspp_periph.sv
/*
  Peripheral model for the handshake port: drives the port lines and the
  input strobe, and counts output strobe pulses.
  Assumes send is called from just after a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module hspp_periph (
  // Clock
  input  wire logic       clk,
  // From the port
  input  wire logic [7:0] port_lines_out,
  input  wire logic [7:0] port_lines_oe_b,
  input  wire logic       strobe_out_pin,
  // To the port
  output var  logic [7:0] port_lines_in,
  output var  logic       strobe_in_pin_in
);
  logic [7:0] drive_q   = 8'h00;
  int         osc_count = 0;

  // Wire level: the port wins on lines it drives
  always_comb port_lines_in = (port_lines_out & ~port_lines_oe_b) |
                              (drive_q & port_lines_oe_b);

  // Count output strobe pulses
  always @(negedge strobe_out_pin) osc_count++;

  // Strobe line pulled up while idle
  initial strobe_in_pin_in = 1'b1;

  // Present data, pulse the strobe low, then let the data go stale
  task automatic send(input logic [7:0] d);
    @(posedge clk);
    drive_q <= d;
    repeat (5) @(posedge clk);
    strobe_in_pin_in <= 1'b0;
    repeat (5) @(posedge clk);
    strobe_in_pin_in <= 1'b1;
    repeat (5) @(posedge clk);
    drive_q <= ~d; // Hold time over: data no longer valid
  endtask : send
endmodule : hspp_periph
`default_nettype wire

// ===== tb/testbench.sv
/*
  Self-checking bench for the handshake parallel port.
  Assumes the peripheral model hspp_periph on the port side.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] A_DIR  = hspp_pkg::IDX_DIR << hspp_pkg::ADDR_LSB;
  localparam logic [7:0] A_DATA = hspp_pkg::IDX_DATA << hspp_pkg::ADDR_LSB;
  localparam logic [7:0] A_CSR  = hspp_pkg::IDX_CSR << hspp_pkg::ADDR_LSB;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, irq_line_b = 1'b1, irq_b;
  logic [7:0]  paddr = 8'h00, lines_in, lines_out, lines_oe_b;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  mode_sel = 3'h4;
  logic        sin_in, sin_out, sin_oe_b, sout, sout_oe_b;
  int          bad_count = 0, compares = 0, n;

  // Design and peripheral
  hspp_port u_hspp_port (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mode_sel(mode_sel), .port_lines_in(lines_in),
    .port_lines_out(lines_out), .port_lines_oe_b(lines_oe_b),
    .strobe_in_pin_in(sin_in), .strobe_in_pin_out(sin_out),
    .strobe_in_pin_oe_b(sin_oe_b), .strobe_out_pin(sout),
    .strobe_out_pin_oe_b(sout_oe_b), .maskable_irq_line_b(irq_line_b),
    .irq_b(irq_b));
  hspp_periph u_hspp_periph (.clk(clk), .port_lines_out(lines_out),
    .port_lines_oe_b(lines_oe_b), .strobe_out_pin(sout),
    .port_lines_in(lines_in), .strobe_in_pin_in(sin_in));

  // Clock
  initial forever #10 clk = ~clk;

  // Compare and count
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // One APB transfer with bounded wait
  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic eerr,
                     output logic [31:0] r);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // Hold the request until pready is seen high at a rising edge
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      summarize();
    end
    r = prdata;
    chk("pslverr", {31'h0, eerr}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 1'b0, rd);
  endtask : wr

  task automatic rchk(input string w, input logic [7:0] a,
                      input logic [31:0] e);
    acc(1'b0, a, 32'h0, 1'b0, rd);
    chk(w, e, rd);
  endtask : rchk

  // Scenarios
  task automatic t_reset;
    rchk("csr reset", A_CSR, 32'h0);
    rchk("dir reset", A_DIR, 32'h0);
    chk("lines oe", 32'hFF, {24'h0, lines_oe_b});
    chk("strobe in oe", 32'h1, {31'h0, sin_oe_b});
    chk("strobe out oe", 32'h0, {31'h0, sout_oe_b});
    wr(A_CSR, 32'hFF);
    rchk("csr rw", A_CSR, 32'h58);
    wr(A_CSR, 32'h0);
  endtask : t_reset

  task automatic t_out_read;
    u_hspp_periph.drive_q <= 8'h3C;
    wr(A_DIR, 32'hF0);
    wr(A_DATA, 32'hA5);
    repeat (6) @(posedge clk);
    chk("lines oe", 32'h0F, {24'h0, lines_oe_b});
    chk("lines out", 32'hA5, {24'h0, lines_out});
    n = u_hspp_periph.osc_count;
    rchk("mixed read", A_DATA, 32'hAC);
    repeat (6) @(posedge clk);
    chk("read strobe", n + 1, u_hspp_periph.osc_count);
  endtask : t_out_read

  task automatic t_wr_strobe;
    wr(A_CSR, 32'h10);
    wr(A_DATA, 32'h5A);
    #1 chk("strobe idle", 32'h1, {31'h0, sout});
    @(posedge clk);
    #1 chk("strobe low", 32'h0, {31'h0, sout});
    @(posedge clk);
    #1 chk("strobe end", 32'h1, {31'h0, sout});
    n = u_hspp_periph.osc_count;
    rchk("data read", A_DATA, 32'h5C);
    repeat (6) @(posedge clk);
    chk("no read strobe", n, u_hspp_periph.osc_count);
  endtask : t_wr_strobe

  task automatic t_latch;
    wr(A_CSR, 32'h48);
    u_hspp_periph.send(8'h36);
    repeat (2) @(posedge clk);
    chk("irq on", 32'h0, {31'h0, irq_b});
    wr(A_DATA, 32'h77);
    rchk("flag kept", A_CSR, 32'hC8);
    rchk("latched", A_DATA, 32'h76);
    rchk("flag clear", A_CSR, 32'h48);
    chk("irq off", 32'h1, {31'h0, irq_b});
    repeat (6) @(posedge clk);
    rchk("reopened", A_DATA, 32'h79);
  endtask : t_latch

  task automatic t_irq_mode;
    wr(A_CSR, 32'h0);
    u_hspp_periph.send(8'h0F);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h1, {31'h0, irq_b});
    irq_line_b <= 1'b0;
    repeat (7) @(posedge clk);
    chk("ext irq", 32'h0, {31'h0, irq_b});
    irq_line_b <= 1'b1;
    wr(A_CSR, 32'h40);
    repeat (7) @(posedge clk);
    chk("flag irq", 32'h0, {31'h0, irq_b});
    mode_sel <= 3'h0;
    repeat (3) @(posedge clk);
    chk("irq mode", 32'h1, {31'h0, irq_b});
    chk("strobe in drv", 32'h0, {31'h0, sin_oe_b});
    chk("strobe in lvl", 32'h1, {31'h0, sin_out});
    chk("lines off", 32'hFF, {24'h0, lines_oe_b});
    acc(1'b0, A_CSR, 32'h0, 1'b1, rd);
    acc(1'b1, A_DATA, 32'h0, 1'b1, rd);
    mode_sel <= 3'h7;
    repeat (3) @(posedge clk);
    acc(1'b0, 8'h00, 32'h0, 1'b1, rd);
    rchk("mode seven", A_CSR, 32'hC0);
  endtask : t_irq_mode

  // Verdict and end of run
  task automatic summarize;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_out_read();
    t_wr_strobe();
    t_latch();
    t_irq_mode();
    summarize();
  end
endmodule : testbench
`default_nettype wire
